/* File: logic/rgp_pkg.sv */
// rgp_pkg: register map, field layout, reset values and timing constants
// for the reset generator block.
// assumes a 10 MHz pclk and an APB master with 32-bit data.
package rgp_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_SYS_CTRL  = 8'h00;
  localparam logic [7:0] OFF_PMU_CTRL  = 8'h04;
  localparam logic [7:0] OFF_POR_PIN   = 8'h08;
  localparam logic [7:0] OFF_POR_TIMER = 8'h0C;
  localparam logic [7:0] OFF_REF_TRIM  = 8'h10;
  localparam logic [7:0] OFF_RF_TRIM   = 8'h14;
  localparam logic [7:0] OFF_CLK_TRIM  = 8'h18;
  localparam logic [7:0] OFF_CPU_RST   = 8'h1C;
  localparam logic [7:0] OFF_SCRATCH   = 8'h20;
  localparam logic [7:0] OFF_STATUS    = 8'h24;

  // ==========================================================
  // field positions
  localparam int unsigned SYS_SWRST_BIT  = 0;
  localparam int unsigned PMU_WAKE_BIT   = 0;
  localparam int unsigned PMU_RCOFF_BIT  = 1;
  localparam int unsigned PIN_SEL_W      = 5;
  localparam int unsigned PIN_POL_BIT    = 5;
  localparam int unsigned POR_TIME_W     = 7;
  localparam int unsigned ST_LAST_POR    = 0;
  localparam int unsigned ST_LAST_HW     = 1;
  localparam int unsigned ST_LAST_SW     = 2;
  localparam int unsigned ST_SRC_ANY     = 3;
  localparam int unsigned ST_RC_EN       = 4;
  localparam int unsigned ST_TRIM_DEF    = 5;
  localparam int unsigned ST_BLK_LSB     = 16;

  // ==========================================================
  // values
  localparam logic [POR_TIME_W-1:0] POR_TIME_MAX = 7'h7F;
  localparam logic [POR_TIME_W-1:0] POR_TIME_RST = 7'h18;
  localparam logic [31:0]           CPU_RST_KEY  = 32'h05FA0004;
  localparam logic [7:0]            REF_TRIM_RST = 8'h80;
  localparam logic [7:0]            RF_TRIM_RST  = 8'h80;
  localparam logic [7:0]            CLK_TRIM_RST = 8'h00;
  localparam int unsigned           TICKS_PER_UNIT = 4096;

  // ==========================================================
  // timing: least width of an internal reset pulse, rounded up
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RST_PULSE_NS  = 1000;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // gpio power-on source selection
  typedef struct packed {
    logic                 polarity;
    logic [PIN_SEL_W-1:0] pin_sel;
  } rgp_pin_cfg_s;

endpackage : rgp_pkg

/* File: logic/rgp_pulse_stretch.sv */
// rgp_pulse_stretch: turns a one-cycle trigger into an active-low reset
// held for a fixed number of pclk cycles, released on a pclk edge.
// assumes trig comes from logic on pclk.
`timescale 1ns/10ps
module rgp_pulse_stretch #(
  parameter int unsigned PULSE = rgp_pkg::RST_PULSE_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trig,
  output logic      rst_n
);

  localparam int unsigned CW = $clog2(PULSE + 1);
  localparam logic [CW-1:0] LOAD = CW'(PULSE);

  logic [CW-1:0] cnt_r;

  // ==========================================================
  // hold counter: starts loaded so the reset also covers power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= LOAD;
    end else if (trig) begin
      cnt_r <= LOAD;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  // RULE19 synchronous release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_n <= 1'b0;
    end else begin
      rst_n <= ~trig && (cnt_r <= CW'(1));
    end
  end

endmodule : rgp_pulse_stretch

/* File: logic/rgp_reset_gen.sv */
// rgp_reset_gen: power-on, hardware and software reset generation with a
// power-on timer, register groups per reset scope, APB register access.
// assumes presetn is the supply power-on reset; pad, gpio and rc clock
// are asynchronous pins; wake_event is a pclk pulse from the power manager.
//
// What this block does
// RULE1: the reset pad is active high; a high level requests reset.
// RULE2: pad or selected gpio held for programmed delay gives power-on reset.
// RULE3: pad released before the delay gives a hardware reset instead.
// RULE4: software reset is the OR of cpu key write and control bit.
// RULE5: with wake bit set, waking from sleep raises a hardware reset.
// RULE6: power-on or hardware reset starts the cold start sequence.
// RULE7: reference and rf trim, pin and timer registers are cleared by power-on reset only.
// RULE8: control and clock trim registers survive software reset only.
// RULE9: all other registers except status are cleared by any of the three resets.
// RULE10: the reset pad can always cause power-on reset.
// RULE11: software may pick one gpio as extra power-on source.
// RULE12: the delay factor is a 7-bit field, maximum 0x7F.
// RULE13: source must hold for factor times 4096 rc clock periods.
// RULE14: timer uses rc oscillator, forced on while a source asserts.
// RULE15: pad source uses reset trim, gpio source keeps programmed trim.
// RULE16: pin number zero disables gpio source; polarity 1 is active high.
// RULE17: timer counts while a source asserts, returns to zero on release.
// RULE18: overlapping sources count continuously across both.
// RULE19: pad and gpio are synchronised; resets release on pclk.
`timescale 1ns/10ps
module rgp_reset_gen #(
  parameter int unsigned GPIO_W         = 32,
  parameter int unsigned TICKS_PER_UNIT = rgp_pkg::TICKS_PER_UNIT
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              reset_pad,
  input  wire logic [GPIO_W-1:0] gpio_in,
  input  wire logic              low_rate_rc_oscillator_clk,
  input  wire logic              wake_event,
  output logic                   por_rst_n,
  output logic                   hw_rst_n,
  output logic                   sw_rst_n,
  output logic                   cold_start,
  output logic                   rc_osc_en,
  output logic                   rc_trim_default
);

  localparam int unsigned TW = $clog2(TICKS_PER_UNIT);
  localparam int unsigned PW = rgp_pkg::POR_TIME_W;

  // ==========================================================
  // synchronisers
  logic              pad_m_r, pad_s_r, pad_d_r;
  logic              rc_m_r, rc_s_r, rc_d_r;
  logic [GPIO_W-1:0] gpio_m_r, gpio_s_r;

  // RULE19 two flops on every pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_m_r  <= 1'b0;
      pad_s_r  <= 1'b0;
      pad_d_r  <= 1'b0;
      rc_m_r   <= 1'b0;
      rc_s_r   <= 1'b0;
      rc_d_r   <= 1'b0;
      gpio_m_r <= '0;
      gpio_s_r <= '0;
    end else begin
      pad_m_r  <= reset_pad;
      pad_s_r  <= pad_m_r;
      pad_d_r  <= pad_s_r;
      rc_m_r   <= low_rate_rc_oscillator_clk;
      rc_s_r   <= rc_m_r;
      rc_d_r   <= rc_s_r;
      gpio_m_r <= gpio_in;
      gpio_s_r <= gpio_m_r;
    end
  end

  // ==========================================================
  // registers and their clears
  rgp_pkg::rgp_pin_cfg_s pin_r;
  logic [PW-1:0]  por_time_r;
  logic [7:0]     ref_trim_r, rf_trim_r, clk_trim_r, scratch_r;
  logic [7:1]     sys_ctrl_r;
  logic           pmu_wake_r, pmu_rcoff_r;
  logic           sw_bit_req_r, cpu_req_r;
  logic           last_por_r, last_hw_r, last_sw_r;
  logic [TW-1:0]  tick_cnt_r;
  logic [PW-1:0]  blk_cnt_r;
  logic           fired_r;
  logic           pready_r, pslverr_r;
  logic [31:0]    prdata_r, rd_nxt;
  logic           err_nxt;

  logic wr_en, src_gpio, src_any, rc_tick, por_fire, hw_pad, hw_fire, sw_fire;
  logic hw_clr, any_clr;

  assign wr_en   = psel && penable && pwrite && pready_r;
  assign rc_tick = rc_s_r && !rc_d_r;
  // RULE16 pin zero disables, polarity picks the active level
  assign src_gpio = (pin_r.pin_sel != '0) && (gpio_s_r[pin_r.pin_sel] == pin_r.polarity);
  // RULE1 RULE10 pad is always a source, active high
  assign src_any  = pad_s_r || src_gpio;
  // RULE2 RULE13 fire once the held time reaches the factor
  assign por_fire = src_any && !fired_r && (blk_cnt_r >= por_time_r);
  // RULE3 short pad pulse; a still-held gpio keeps the count alive
  assign hw_pad   = pad_d_r && !pad_s_r && !fired_r && !src_gpio;
  // RULE5 wake-up reset
  assign hw_fire  = hw_pad || (wake_event && pmu_wake_r);
  // RULE4 soft reset from either request
  assign sw_fire  = sw_bit_req_r || cpu_req_r;
  assign hw_clr   = por_fire || hw_fire;
  assign any_clr  = hw_clr || sw_fire;

  // RULE7 RULE11 RULE12 power-on-only group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r      <= '0;
      por_time_r <= rgp_pkg::POR_TIME_RST;
      ref_trim_r <= rgp_pkg::REF_TRIM_RST;
      rf_trim_r  <= rgp_pkg::RF_TRIM_RST;
    end else if (por_fire) begin
      pin_r      <= '0;
      por_time_r <= rgp_pkg::POR_TIME_RST;
      ref_trim_r <= rgp_pkg::REF_TRIM_RST;
      rf_trim_r  <= rgp_pkg::RF_TRIM_RST;
    end else if (wr_en) begin
      if (paddr == rgp_pkg::OFF_POR_PIN) begin
        pin_r <= rgp_pkg::rgp_pin_cfg_s'(pwdata[rgp_pkg::PIN_POL_BIT:0]);
      end
      if (paddr == rgp_pkg::OFF_POR_TIMER) por_time_r <= pwdata[PW-1:0];
      if (paddr == rgp_pkg::OFF_REF_TRIM) ref_trim_r <= pwdata[7:0];
      if (paddr == rgp_pkg::OFF_RF_TRIM) rf_trim_r <= pwdata[7:0];
    end
  end

  // RULE8 power-on or hardware group, kept through soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_ctrl_r  <= '0;
      pmu_wake_r  <= 1'b0;
      pmu_rcoff_r <= 1'b0;
      clk_trim_r  <= rgp_pkg::CLK_TRIM_RST;
    end else if (hw_clr) begin
      sys_ctrl_r  <= '0;
      pmu_wake_r  <= 1'b0;
      pmu_rcoff_r <= 1'b0;
      clk_trim_r  <= rgp_pkg::CLK_TRIM_RST;
    end else if (wr_en) begin
      if (paddr == rgp_pkg::OFF_SYS_CTRL) sys_ctrl_r <= pwdata[7:1];
      if (paddr == rgp_pkg::OFF_PMU_CTRL) begin
        pmu_wake_r  <= pwdata[rgp_pkg::PMU_WAKE_BIT];
        pmu_rcoff_r <= pwdata[rgp_pkg::PMU_RCOFF_BIT];
      end
      if (paddr == rgp_pkg::OFF_CLK_TRIM) clk_trim_r <= pwdata[7:0];
    end
  end

  // RULE9 scratch clears on any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_r <= '0;
    end else if (any_clr) begin
      scratch_r <= '0;
    end else if (wr_en && paddr == rgp_pkg::OFF_SCRATCH) begin
      scratch_r <= pwdata[7:0];
    end
  end

  // RULE4 soft reset requests, self clearing; blocked while a reset fires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_bit_req_r <= 1'b0;
      cpu_req_r    <= 1'b0;
    end else begin
      sw_bit_req_r <= wr_en && !any_clr && paddr == rgp_pkg::OFF_SYS_CTRL
                      && pwdata[rgp_pkg::SYS_SWRST_BIT];
      cpu_req_r    <= wr_en && !any_clr && paddr == rgp_pkg::OFF_CPU_RST
                      && pwdata == rgp_pkg::CPU_RST_KEY;
    end
  end

  // last reset cause; only supply power-up clears it so software can read it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_por_r <= 1'b0;
      last_hw_r  <= 1'b0;
      last_sw_r  <= 1'b0;
    end else if (any_clr) begin
      last_por_r <= por_fire;
      last_hw_r  <= hw_fire && !por_fire;
      last_sw_r  <= !hw_clr;
    end
  end

  // ==========================================================
  // power-on timer
  // RULE13 RULE17 RULE18 count rc edges while any source holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
      blk_cnt_r  <= '0;
    end else if (!src_any) begin
      tick_cnt_r <= '0;
      blk_cnt_r  <= '0;
    end else if (rc_tick) begin
      if (tick_cnt_r == TW'(TICKS_PER_UNIT - 1)) begin
        tick_cnt_r <= '0;
        if (blk_cnt_r != rgp_pkg::POR_TIME_MAX) blk_cnt_r <= blk_cnt_r + PW'(1);
      end else begin
        tick_cnt_r <= tick_cnt_r + TW'(1);
      end
    end
  end

  // one power-on reset per assertion; rearms when all sources release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fired_r <= 1'b0;
    end else if (!src_any) begin
      fired_r <= 1'b0;
    end else if (por_fire) begin
      fired_r <= 1'b1;
    end
  end

  // ==========================================================
  // reset outputs and oscillator control
  // RULE6 cold start pulse; RULE14 forced oscillator; RULE15 trim choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cold_start      <= 1'b0;
      rc_osc_en       <= 1'b1;
      rc_trim_default <= 1'b1;
    end else begin
      cold_start      <= hw_clr;
      rc_osc_en       <= !pmu_rcoff_r || src_any;
      rc_trim_default <= pad_s_r;
    end
  end

  rgp_pulse_stretch u_por (.pclk(pclk), .presetn(presetn), .trig(por_fire), .rst_n(por_rst_n));
  rgp_pulse_stretch u_hw  (.pclk(pclk), .presetn(presetn), .trig(hw_clr),   .rst_n(hw_rst_n));
  rgp_pulse_stretch u_sw  (.pclk(pclk), .presetn(presetn), .trig(any_clr),  .rst_n(sw_rst_n));

  // ==========================================================
  // apb slave: read data captured in setup, one access cycle
  always_comb begin
    rd_nxt  = '0;
    err_nxt = 1'b0;
    unique case (paddr)
      rgp_pkg::OFF_SYS_CTRL:  rd_nxt[7:1] = sys_ctrl_r;
      rgp_pkg::OFF_PMU_CTRL:  rd_nxt[1:0] = {pmu_rcoff_r, pmu_wake_r};
      rgp_pkg::OFF_POR_PIN:   rd_nxt[rgp_pkg::PIN_POL_BIT:0] = pin_r;
      rgp_pkg::OFF_POR_TIMER: rd_nxt[PW-1:0] = por_time_r;
      rgp_pkg::OFF_REF_TRIM:  rd_nxt[7:0] = ref_trim_r;
      rgp_pkg::OFF_RF_TRIM:   rd_nxt[7:0] = rf_trim_r;
      rgp_pkg::OFF_CLK_TRIM:  rd_nxt[7:0] = clk_trim_r;
      rgp_pkg::OFF_CPU_RST:   rd_nxt = '0;
      rgp_pkg::OFF_SCRATCH:   rd_nxt[7:0] = scratch_r;
      rgp_pkg::OFF_STATUS: begin
        rd_nxt[rgp_pkg::ST_LAST_POR] = last_por_r;
        rd_nxt[rgp_pkg::ST_LAST_HW]  = last_hw_r;
        rd_nxt[rgp_pkg::ST_LAST_SW]  = last_sw_r;
        rd_nxt[rgp_pkg::ST_SRC_ANY]  = src_any;
        rd_nxt[rgp_pkg::ST_RC_EN]    = rc_osc_en;
        rd_nxt[rgp_pkg::ST_TRIM_DEF] = rc_trim_default;
        rd_nxt[rgp_pkg::ST_BLK_LSB +: PW] = blk_cnt_r;
      end
      default: err_nxt = 1'b1; // unmapped: error, data zero
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && err_nxt;
      if (psel && !penable && !pwrite) begin
        prdata_r <= rd_nxt;
      end
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pad_is_source: assert property (pad_s_r && rc_tick // RULE1
      |=> tick_cnt_r != $past(tick_cnt_r))
    else $error("pad high does not run the timer");
  a_por_needs_time: assert property ($fell(por_rst_n) // RULE2
      |-> $past(src_any) && $past(blk_cnt_r) >= $past(por_time_r))
    else $error("power-on reset before delay elapsed");
  a_short_pad_hw: assert property (hw_pad |=> ##[0:2] !hw_rst_n && por_rst_n) // RULE3
    else $error("short pad pulse did not give hardware reset");
  a_cpu_key_sw: assert property (wr_en && paddr == rgp_pkg::OFF_CPU_RST
      && pwdata == rgp_pkg::CPU_RST_KEY && !any_clr |=> ##1 !sw_rst_n) // RULE4
    else $error("cpu key write gave no soft reset");
  a_wake_hw: assert property (wake_event && pmu_wake_r |=> ##1 !hw_rst_n) // RULE5
    else $error("wake did not give hardware reset");
  a_cold_start: assert property (hw_clr |=> cold_start) // RULE6
    else $error("no cold start after reset");
  a_por_only_keep: assert property (hw_fire && !por_fire && !wr_en
      |=> $stable(ref_trim_r) && $stable(por_time_r)) // RULE7
    else $error("power-on-only register lost on hardware reset");
  a_hw_grp_keep: assert property (sw_fire && !hw_clr && !wr_en
      |=> $stable(clk_trim_r) && $stable(pmu_wake_r)) // RULE8
    else $error("hardware group lost on soft reset");
  a_all_clear: assert property (sw_fire |=> scratch_r == 8'h00) // RULE9
    else $error("scratch survived soft reset");
  a_timer_zero: assert property (!src_any |=> blk_cnt_r == '0 && tick_cnt_r == '0) // RULE17
    else $error("timer not zero after release");
  a_osc_forced: assert property (src_any |=> rc_osc_en) // RULE14
    else $error("oscillator not forced on");
  a_trim_pick: assert property (src_gpio && !pad_s_r |=> !rc_trim_default) // RULE15
    else $error("gpio source lost programmed trim");

  c_por_pad: cover property (pad_s_r && por_fire);
  c_por_gpio: cover property (src_gpio && !pad_s_r && por_fire);
  c_hw_short: cover property (hw_pad);
  c_sw_bit: cover property (sw_bit_req_r);

endmodule : rgp_reset_gen

/* File: tb/rgp_board_src.sv */
// rgp_board_src: board side of the reset block: pad driver, gpio
// drivers and the low-rate rc oscillator.
// assumes the bench sets pad_req and gpio_req; rc runs on rc_osc_en.
`timescale 1ns/10ps
module rgp_board_src #(
  parameter int unsigned GPIO_W  = 32,
  parameter int unsigned HALF_NS = 453
) (
  input  wire logic              rc_osc_en,
  input  wire logic              pad_req,
  input  wire logic [GPIO_W-1:0] gpio_req,
  output logic                   reset_pad,
  output logic      [GPIO_W-1:0] gpio_in,
  output logic                   low_rate_rc_oscillator_clk
);
  // ==========================================================
  // pins
  // high pad requests
  assign reset_pad = pad_req;
  assign gpio_in   = gpio_req;

  // ==========================================================
  // oscillator
  // runs only enabled
  // half period is no multiple of pclk, so the phase drifts
  initial low_rate_rc_oscillator_clk = 1'b0;
  always begin
    #(HALF_NS);
    if (rc_osc_en === 1'b1)
      low_rate_rc_oscillator_clk = ~low_rate_rc_oscillator_clk;
    else
      low_rate_rc_oscillator_clk = 1'b0;
  end
endmodule : rgp_board_src

/* File: tb/tb_reset_generation_por_timer.sv */
// tb_reset_generation_por_timer: self-checking bench for the reset block,
// with a register model per reset scope and rc edge counting.
// assumes rgp_board_src as the board and TICKS_PER_UNIT of 4.
`timescale 1ns/10ps
module tb_reset_generation_por_timer;
  localparam int unsigned TPU = 4;
  localparam logic [31:0] MSK [9] = '{32'hFE, 32'h3, 32'h3F, 32'h7F, 32'hFF,
                                     32'hFF, 32'hFF, 32'h0, 32'hFF};
  localparam logic [31:0] RV [9]  = '{32'h0, 32'h0, 32'h0, 32'h18, 32'h80,
                                     32'h80, 32'h0, 32'h0, 32'h0};
  localparam int          GRP [9] = '{1, 1, 2, 2, 2, 2, 1, 0, 0};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, gpio_in, gpio_req, seed;
  logic        reset_pad, low_rate_rc_oscillator_clk, wake_event, pad_req;
  logic        por_rst_n, hw_rst_n, sw_rst_n, cold_start, rc_osc_en, rc_trim_default;
  logic [31:0] mdl [9];
  int          miscompares, compares, rc_cnt, fire_cnt;

  rgp_reset_gen #(.GPIO_W(32), .TICKS_PER_UNIT(TPU)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pad(reset_pad), .gpio_in(gpio_in),
    .low_rate_rc_oscillator_clk(low_rate_rc_oscillator_clk), .wake_event(wake_event), .por_rst_n(por_rst_n),
    .hw_rst_n(hw_rst_n), .sw_rst_n(sw_rst_n), .cold_start(cold_start),
    .rc_osc_en(rc_osc_en), .rc_trim_default(rc_trim_default));
  rgp_board_src #(.GPIO_W(32)) src (.rc_osc_en(rc_osc_en), .pad_req(pad_req),
    .gpio_req(gpio_req), .reset_pad(reset_pad), .gpio_in(gpio_in),
    .low_rate_rc_oscillator_clk(low_rate_rc_oscillator_clk));

  // ==========================================================
  // clock and helpers
  always #50 pclk = ~pclk;
  // rc edges since the source went up
  always @(posedge low_rate_rc_oscillator_clk) rc_cnt++;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // apb transfer: entered just after a rising edge, holds until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20) miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input int i, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, 8'(i * 4), d, r, e);
    mdl[i] = d & MSK[i];
  endtask : wr

  task automatic rd_all();
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 8'(i * 4), xs(), r, e);
      check(r, mdl[i]);
    end
  endtask : rd_all

  // random contents; soft reset bit, wake bit and key kept clear
  task automatic wr_all();
    logic [31:0] d;
    for (int i = 0; i < 9; i++) begin
      d = xs();
      d[0] = (i == 0 || i == 1) ? 1'b0 : d[0];
      d[5] = (i == 2) ? 1'b0 : d[5];
      wr(i, (i == 7) ? 32'h0 : d);
    end
  endtask : wr_all

  task automatic wait_sw(input logic v, input int lim);
    int n;
    n = 0;
    while (sw_rst_n !== v && n < lim) begin
      n++;
      @(posedge pclk);
    end
    check(32'(sw_rst_n), 32'(v));
  endtask : wait_sw

  // k: 2 power-on, 1 hardware, 0 software
  task automatic wait_rst(input int k);
    logic [31:0] r;
    logic        e;
    wait_sw(1'b0, 400);
    fire_cnt = rc_cnt;
    check(32'(por_rst_n), 32'(k != 2));
    check(32'(hw_rst_n), 32'(k == 0));
    check(32'(cold_start), 32'(k != 0));
    wait_sw(1'b1, 40);
    // last cause in status: bit 0 power-on, bit 1 hardware, bit 2 software
    apb(1'b0, 8'h24, 32'h0, r, e);
    check(r & 32'h7, 32'h1 << (2 - k));
    for (int i = 0; i < 9; i++)
      mdl[i] = (GRP[i] <= k) ? RV[i] : mdl[i];
  endtask : wait_rst

  task automatic quiet(input int n, input logic rnd);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      gpio_req <= rnd ? xs() : gpio_req;
      @(posedge pclk);
      bad = bad | (sw_rst_n !== 1'b1);
    end
    check(32'(bad), 32'h0);
  endtask : quiet

  task automatic wait_rc(input int k);
    int n;
    n = 0;
    while (rc_cnt < k && n < 500) begin
      n++;
      @(posedge pclk);
    end
    if (rc_cnt < k) miscompares++;
  endtask : wait_rc

  task automatic wake();
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
  endtask : wake

  // ==========================================================
  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    #(2000000);
    miscompares++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    logic [4:0]  pin;
    logic        pol;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, wake_event, pad_req} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    gpio_req = 32'hFFFFFFFF;
    seed = 32'h18;
    miscompares = 0;
    compares = 0;
    for (int i = 0; i < 9; i++)
      mdl[i] = RV[i];
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_sw(1'b1, 40);
    rd_all();
    // unmapped place is refused
    apb(1'b0, 8'h28, 32'h0, r, e);
    check({r[30:0], e}, 32'h1);
    apb(1'b1, 8'h2C, xs(), r, e);
    check(32'(e), 32'h1);
    // software reset from key write and from control bit
    wr_all();
    wr(7, xs() & 32'hFFFF0000);
    quiet(20, 1'b0);
    for (int m = 0; m < 2; m++) begin
      wr_all();
      wr(m == 0 ? 7 : 0, m == 0 ? 32'h05FA0004 : 32'h1);
      wait_rst(0);
      rd_all();
    end
    // wake with and without the wake bit
    wr(1, 32'h0);
    wake();
    quiet(20, 1'b0);
    wr(1, 32'h1);
    wake();
    wait_rst(1);
    rd_all();
    // short pad pulse with oscillator switched off
    wr(3, 32'h2);
    wr(1, 32'h2);
    repeat (3) @(posedge pclk);
    check(32'(rc_osc_en), 32'h0);
    pad_req <= 1'b1;
    rc_cnt = 0;
    wait_rc(6);
    check(32'(rc_osc_en), 32'h1);
    check(32'(rc_trim_default), 32'h1);
    check(32'(sw_rst_n), 32'h1);
    pad_req <= 1'b0;
    wait_rst(1);
    rd_all();
    // long pad: full delay again after the earlier release
    wr(1, 32'h2);
    repeat (3) @(posedge pclk);
    pad_req <= 1'b1;
    rc_cnt = 0;
    wait_rst(2);
    check(fire_cnt, 2 * TPU);
    pad_req <= 1'b0;
    quiet(30, 1'b0);
    rd_all();
    // gpio source off, then random pin and polarity overlapping the pad
    r = xs();
    pin = 5'(r % 31 + 1);
    pol = r[8];
    wr(3, 32'h2);
    wr(1, 32'h2);
    wr(2, 32'h0);
    quiet(40, 1'b1);
    gpio_req <= {32{~pol}};
    wr(2, {26'h0, pol, pin});
    gpio_req[pin] <= pol;
    rc_cnt = 0;
    wait_rc(4);
    check(32'(rc_trim_default), 32'h0);
    check(32'(rc_osc_en), 32'h1);
    pad_req <= 1'b1;
    wait_rc(6);
    gpio_req[pin] <= ~pol;
    wait_rst(2);
    check(fire_cnt, 2 * TPU);
    pad_req <= 1'b0;
    rd_all();
    close_out();
  end
endmodule : tb_reset_generation_por_timer
